// *** design/dnm_pkg.sv ***
package dnm_pkg;

    // clock and timing
    localparam int unsigned DNM_CLK_KHZ  = 250000;
    localparam int unsigned DNM_LOOP_MS  = 1000;
    localparam int unsigned DNM_LOOP_CYC = DNM_LOOP_MS * DNM_CLK_KHZ;
    localparam int unsigned DNM_LOOP_W   = 28;
    // traction value request is due this long after run entry; the engine sends it right after the run-entry service load
    localparam int unsigned DNM_TRQ_LAT_MS = 750;

    // header bytes
    localparam logic [7:0] DNM_B0_LOAD   = 8'h8a;
    localparam logic [7:0] DNM_B0_RPT    = 8'haa;
    localparam logic [7:0] DNM_B0_REQ    = 8'hcb;
    localparam logic [7:0] DNM_B1_LOAD   = 8'hea;
    localparam logic [7:0] DNM_B1_REPLY  = 8'heb;
    localparam logic [3:0] DNM_LO_LOAD   = 4'ha;
    localparam logic [3:0] DNM_LO_REQ    = 4'hb;
    localparam logic [7:0] DNM_SRC_ENG   = 8'h10;
    localparam logic [7:0] DNM_SRC_BODY  = 8'h40;
    localparam logic [7:0] DNM_B3_DIS    = 8'h20;
    localparam logic [7:0] DNM_B3_EN     = 8'ha0;
    localparam logic [7:0] DNM_SIG_SSO   = 8'h8f;
    localparam logic [7:0] DNM_SIG_TRAC  = 8'h9b;
    localparam logic [7:0] DNM_PKT_ZERO  = 8'h00;

    // engine end apb registers
    localparam logic [7:0] DNM_REG_CTRL  = 8'h00;
    localparam logic [7:0] DNM_REG_STAT  = 8'h04;
    localparam logic [7:0] DNM_REG_CNT   = 8'h08;
    localparam int unsigned DNM_CTRL_RUN   = 0;
    localparam int unsigned DNM_CTRL_FAULT = 1;
    localparam int unsigned DNM_CTRL_LHL   = 2;
    localparam int unsigned DNM_STAT_TRAC  = 0;
    localparam int unsigned DNM_STAT_SENT  = 1;
    localparam int unsigned DNM_STAT_RPTEN = 2;
    localparam int unsigned DNM_STAT_MATCH = 3;
    localparam int unsigned DNM_STAT_TPKT  = 8;
    localparam logic [2:0] DNM_CTRL_RST  = 3'h0;

    function automatic logic [39:0] dnm_hdr(input logic [7:0] b0,
                                            input logic [7:0] b1,
                                            input logic [7:0] src,
                                            input logic       en,
                                            input logic [7:0] sig);
        dnm_hdr = {b0, b1, src, (en ? DNM_B3_EN : DNM_B3_DIS), sig};
    endfunction : dnm_hdr

endpackage : dnm_pkg

// *** design/dnm_link_if.sv ***
`timescale 1ns/100ps
interface dnm_link_if;
    logic        e2b_valid;
    logic [39:0] e2b_hdr;
    logic [7:0]  e2b_pkt;
    logic        b2e_valid;
    logic [39:0] b2e_hdr;
    logic [7:0]  b2e_pkt;

    modport engine (output e2b_valid, e2b_hdr, e2b_pkt,
                    input  b2e_valid, b2e_hdr, b2e_pkt);
    modport body   (input  e2b_valid, e2b_hdr, e2b_pkt,
                    output b2e_valid, b2e_hdr, b2e_pkt);
endinterface : dnm_link_if

// *** design/dnm_rx_decode.sv ***
`timescale 1ns/100ps
module dnm_rx_decode
    import dnm_pkg::*;
(
    // received message
    input  wire logic        valid,
    input  wire logic [39:0] hdr,
    // decoded kind
    output logic             acc_load,
    output logic             acc_rpt,
    output logic             acc_req,
    output logic [7:0]       sig,
    output logic             en
);
    logic even;

    // odd upper nibble means the frame is not for us
    assign even     = valid & ~hdr[36];
    assign acc_load = even & (hdr[31:24] == DNM_B1_LOAD)
                    & (hdr[35:32] == DNM_LO_LOAD);
    assign acc_rpt  = even & (hdr[31:24] == DNM_B1_REPLY)
                    & (hdr[35:32] == DNM_LO_LOAD);
    assign acc_req  = even & (hdr[31:24] == DNM_B1_REPLY)
                    & (hdr[35:32] == DNM_LO_REQ);
    assign sig      = hdr[7:0];
    assign en       = hdr[15];
endmodule : dnm_rx_decode

// *** design/dnm_engine_end.sv ***
// What this block does
// - engine sends service load on change
// - service load header 8a ea 10 20/a0 8f
// - detected failure sends state flag one
// - engine load payload always zero
// - failure evaluated every 1000 ms
// - body answers service load with report
// - value request answered with service load
// - accept only even upper header nibble
// - receive actions only in run mode
// - body sends traction load on change
// - body sets flag when traction off
// - engine requests traction value after run entry
// - engine never reports traction load
// - traction state disabled at reset, health loss
`timescale 1ns/100ps
module dnm_engine_end
    import dnm_pkg::*;
#(
    parameter int unsigned LOOP_CYCLES = DNM_LOOP_CYC
)(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // traction state for the control algorithm
    output logic             trac_off,
    // network side
    dnm_link_if.engine       link
);
    logic [2:0]            ctrl_q;
    logic                  run_prev_q;
    logic [DNM_LOOP_W-1:0] loop_cnt_q;
    logic                  sso_eval_q;
    logic                  sso_sent_q;
    logic                  pend_sso_q;
    logic                  pend_trq_q;
    logic                  trac_q;
    logic [7:0]            trac_pkt_q;
    logic                  rpt_en_q;
    logic [15:0]           tx_cnt_q;
    logic [15:0]           rpt_cnt_q;
    logic                  tx_valid_q;
    logic [39:0]           tx_hdr_q;
    logic [7:0]            tx_pkt_q;
    logic [31:0]           prdata_q;
    logic                  pready_q;
    logic                  pslverr_q;

    logic run;
    logic run_entry;
    logic tick;
    logic sso_chg;
    logic set_sso;
    logic send_sso;
    logic send_trq;
    logic acc_load;
    logic acc_rpt;
    logic acc_req;
    logic [7:0] rx_sig;
    logic rx_en;
    logic apb_wr;
    logic apb_setup;

    assign run       = ctrl_q[DNM_CTRL_RUN];
    assign run_entry = run & ~run_prev_q;
    assign apb_setup = psel & ~penable;
    assign apb_wr    = psel & penable & pready_q & pwrite;

    dnm_rx_decode u_dec (
        .valid    (link.b2e_valid),
        .hdr      (link.b2e_hdr),
        .acc_load (acc_load),
        .acc_rpt  (acc_rpt),
        .acc_req  (acc_req),
        .sig      (rx_sig),
        .en       (rx_en)
    );

    // apb register file, zero wait states
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_q <= DNM_CTRL_RST;
        else if (apb_wr && paddr == DNM_REG_CTRL)
            ctrl_q <= pwdata[2:0];
    end

    // read data is captured in setup so it stands through the access
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_q  <= 32'h0;
            pslverr_q <= 1'b0;
            pready_q  <= 1'b0;
        end
        else
        begin
            pready_q <= 1'b1;
            if (apb_setup)
            begin
                pslverr_q <= 1'b0;
                prdata_q  <= 32'h0;
                case (paddr)
                    DNM_REG_CTRL: prdata_q <= {29'h0, ctrl_q};
                    DNM_REG_STAT: prdata_q <= {16'h0, trac_pkt_q,
                                               4'h0,
                                               (rpt_en_q == sso_sent_q),
                                               rpt_en_q, sso_sent_q,
                                               trac_q};
                    DNM_REG_CNT:  prdata_q <= {rpt_cnt_q, tx_cnt_q};
                    default:      pslverr_q <= 1'b1;
                endcase
            end
        end
    end

    // application loop timer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            loop_cnt_q <= '0;
        else if (!run || tick)
            loop_cnt_q <= '0;
        else
            loop_cnt_q <= loop_cnt_q + 1'b1;
    end
    assign tick = run
        & (loop_cnt_q == DNM_LOOP_W'(LOOP_CYCLES - 1));

    // failure evaluation: flag follows the fault bit once a loop
    assign sso_chg = tick
        & (ctrl_q[DNM_CTRL_FAULT] != sso_eval_q);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            run_prev_q <= 1'b0;
            sso_eval_q <= 1'b0;
        end
        else
        begin
            run_prev_q <= run;
            if (run_entry || tick)
                sso_eval_q <= ctrl_q[DNM_CTRL_FAULT];
        end
    end

    // change, mode entry and request share one pending flag
    assign set_sso = run & (run_entry | sso_chg
                   | (acc_req & rx_sig == DNM_SIG_SSO));
    assign send_sso = run & pend_sso_q;
    assign send_trq = run & pend_trq_q & ~pend_sso_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pend_sso_q <= 1'b0;
        else if (!run)
            pend_sso_q <= 1'b0;
        else if (set_sso)
            pend_sso_q <= 1'b1;
        else if (send_sso)
            pend_sso_q <= 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pend_trq_q <= 1'b0;
        else if (!run)
            pend_trq_q <= 1'b0;
        else if (run_entry)
            pend_trq_q <= 1'b1;
        else if (send_trq)
            pend_trq_q <= 1'b0;
    end

    // transmitter, one message per cycle at most
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_valid_q <= 1'b0;
            tx_hdr_q   <= 40'h0;
            tx_pkt_q   <= DNM_PKT_ZERO;
            sso_sent_q <= 1'b0;
            tx_cnt_q   <= 16'h0;
        end
        else
        begin
            tx_valid_q <= send_sso | send_trq;
            tx_pkt_q   <= DNM_PKT_ZERO;
            if (send_sso)
            begin
                tx_hdr_q   <= dnm_hdr(DNM_B0_LOAD, DNM_B1_LOAD,
                                      DNM_SRC_ENG, sso_eval_q,
                                      DNM_SIG_SSO);
                sso_sent_q <= sso_eval_q;
                tx_cnt_q   <= tx_cnt_q + 16'h1;
            end
            else if (send_trq)
            begin
                tx_hdr_q <= dnm_hdr(DNM_B0_REQ, DNM_B1_REPLY,
                                    DNM_SRC_ENG, 1'b0,
                                    DNM_SIG_TRAC);
                tx_cnt_q <= tx_cnt_q + 16'h1;
            end
        end
    end

    // traction state is only monitored, never answered
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            trac_q     <= 1'b0;
            trac_pkt_q <= DNM_PKT_ZERO;
        end
        else if (ctrl_q[DNM_CTRL_LHL])
        begin
            trac_q     <= 1'b0;
            trac_pkt_q <= DNM_PKT_ZERO;
        end
        else if (run && acc_load && rx_sig == DNM_SIG_TRAC)
        begin
            trac_q     <= rx_en;
            trac_pkt_q <= link.b2e_pkt;
        end
    end

    // feedback reports only show that the body saw the last load
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rpt_en_q  <= 1'b0;
            rpt_cnt_q <= 16'h0;
        end
        else if (run && acc_rpt && rx_sig == DNM_SIG_SSO)
        begin
            rpt_en_q  <= rx_en;
            rpt_cnt_q <= rpt_cnt_q + 16'h1;
        end
    end

    assign prdata         = prdata_q;
    assign pready         = pready_q;
    assign pslverr        = pslverr_q;
    assign trac_off       = trac_q;
    assign link.e2b_valid = tx_valid_q;
    assign link.e2b_hdr   = tx_hdr_q;
    assign link.e2b_pkt   = tx_pkt_q;
endmodule : dnm_engine_end

// *** design/dnm_body_end.sv ***
`timescale 1ns/100ps
module dnm_body_end
    import dnm_pkg::*;
(
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // user side
    input  wire logic run,
    input  wire logic trac_switch,
    input  wire logic sso_req,
    output logic      sso_lamp,
    output logic      trac_off,
    // network side
    dnm_link_if.body  link
);
    logic        sw_meta_q;
    logic        sw_sync_q;
    logic        trac_q;
    logic        run_prev_q;
    logic        lamp_q;
    logic        rpt_en_q;
    logic        pend_rpt_q;
    logic        pend_tld_q;
    logic        pend_req_q;
    logic        tx_valid_q;
    logic [39:0] tx_hdr_q;
    logic [7:0]  tx_pkt_q;

    logic acc_load;
    logic acc_req;
    logic [7:0] rx_sig;
    logic rx_en;
    logic got_sso;
    logic set_tld;
    logic send_rpt;
    logic send_tld;
    logic send_req;

    dnm_rx_decode u_dec (
        .valid    (link.e2b_valid),
        .hdr      (link.e2b_hdr),
        .acc_load (acc_load),
        .acc_rpt  (),
        .acc_req  (acc_req),
        .sig      (rx_sig),
        .en       (rx_en)
    );

    // driver switch is a pin
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sw_meta_q  <= 1'b0;
            sw_sync_q  <= 1'b0;
            trac_q     <= 1'b0;
            run_prev_q <= 1'b0;
        end
        else
        begin
            sw_meta_q  <= trac_switch;
            sw_sync_q  <= sw_meta_q;
            trac_q     <= sw_sync_q;
            run_prev_q <= run;
        end
    end

    assign got_sso  = run & acc_load & (rx_sig == DNM_SIG_SSO);
    assign set_tld  = run & ((run & ~run_prev_q) | (sw_sync_q != trac_q)
                    | (acc_req & rx_sig == DNM_SIG_TRAC));
    assign send_rpt = run & pend_rpt_q;
    assign send_tld = run & pend_tld_q & ~pend_rpt_q;
    assign send_req = run & pend_req_q & ~pend_rpt_q & ~pend_tld_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lamp_q     <= 1'b0;
            rpt_en_q   <= 1'b0;
            pend_rpt_q <= 1'b0;
        end
        else if (got_sso)
        begin
            lamp_q     <= rx_en;
            rpt_en_q   <= rx_en;
            pend_rpt_q <= 1'b1;
        end
        else if (send_rpt || !run)
            pend_rpt_q <= 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pend_tld_q <= 1'b0;
        else if (set_tld)
            pend_tld_q <= 1'b1;
        else if (send_tld || !run)
            pend_tld_q <= 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pend_req_q <= 1'b0;
        else if (run && sso_req)
            pend_req_q <= 1'b1;
        else if (send_req || !run)
            pend_req_q <= 1'b0;
    end

    // report outranks the others so feedback is never starved
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_valid_q <= 1'b0;
            tx_hdr_q   <= 40'h0;
            tx_pkt_q   <= DNM_PKT_ZERO;
        end
        else
        begin
            tx_valid_q <= send_rpt | send_tld | send_req;
            tx_pkt_q   <= DNM_PKT_ZERO;
            if (send_rpt)
                tx_hdr_q <= dnm_hdr(DNM_B0_RPT, DNM_B1_REPLY,
                                    DNM_SRC_BODY, rpt_en_q,
                                    DNM_SIG_SSO);
            else if (send_tld)
                tx_hdr_q <= dnm_hdr(DNM_B0_LOAD, DNM_B1_LOAD,
                                    DNM_SRC_BODY, trac_q,
                                    DNM_SIG_TRAC);
            else if (send_req)
                tx_hdr_q <= dnm_hdr(DNM_B0_REQ, DNM_B1_REPLY,
                                    DNM_SRC_BODY, 1'b0,
                                    DNM_SIG_SSO);
        end
    end

    assign sso_lamp       = lamp_q;
    assign trac_off       = trac_q;
    assign link.b2e_valid = tx_valid_q;
    assign link.b2e_hdr   = tx_hdr_q;
    assign link.b2e_pkt   = tx_pkt_q;
endmodule : dnm_body_end

// *** testbench/dnm_link_checker.sv ***
`timescale 1ns/100ps
module dnm_link_checker
    import dnm_pkg::*;
(
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // engine to body
    input wire logic        e2b_valid,
    input wire logic [39:0] e2b_hdr,
    input wire logic [7:0]  e2b_pkt,
    // body to engine
    input wire logic        b2e_valid,
    input wire logic [39:0] b2e_hdr,
    input wire logic [7:0]  b2e_pkt
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_eng_pkt_zero: assert property (
        e2b_valid |-> e2b_pkt == 8'h00)
        else $error("engine payload not zero");
    a_eng_hdr_form: assert property (
        e2b_valid |-> e2b_hdr == 40'hcbeb10209b
        || (e2b_hdr[39:16] == 24'h8aea10 && e2b_hdr[7:0] == 8'h8f
        && (e2b_hdr[15:8] == 8'h20 || e2b_hdr[15:8] == 8'ha0)))
        else $error("engine header malformed");
    a_rpt_follows: assert property (
        e2b_valid && e2b_hdr[39:32] == 8'h8a |-> ##2 b2e_valid
        && b2e_hdr == {16'haaeb, 8'h40, $past(e2b_hdr[15:8], 2), 8'h8f})
        else $error("feedback report missing or wrong");
    a_trac_answer: assert property (
        e2b_valid && e2b_hdr == 40'hcbeb10209b |-> ##[2:3] b2e_valid
        && b2e_hdr[39:32] == 8'h8a && b2e_hdr[7:0] == 8'h9b)
        else $error("traction request unanswered");
    a_body_trac_form: assert property (
        b2e_valid && b2e_hdr[7:0] == 8'h9b |-> b2e_hdr[39:16] == 24'h8aea40
        && (b2e_hdr[15:8] == 8'h20 || b2e_hdr[15:8] == 8'ha0))
        else $error("traction load header malformed");
    a_body_req_form: assert property (
        b2e_valid && b2e_hdr[39:32] == 8'hcb |-> b2e_hdr == 40'hcbeb40208f)
        else $error("value request header malformed");
    a_e2b_hold: assert property (
        !e2b_valid |-> $stable(e2b_hdr) && $stable(e2b_pkt))
        else $error("engine header changed without strobe");
    a_b2e_hold: assert property (
        !b2e_valid |-> $stable(b2e_hdr))
        else $error("body header changed without strobe");
endmodule : dnm_link_checker

// *** testbench/driver_notice_msg_handler_tb.sv ***
`timescale 1ns/100ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_count++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module driver_notice_msg_handler_tb
    import dnm_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic        eng_trac, run, trac_sw, sso_req, lamp, body_trac;
    logic        run2, lamp2;
    int          err_count, n_tests;
    dnm_link_if  link();
    dnm_link_if  link2();

    // short loop period keeps the fault evaluation within a few cycles
    dnm_engine_end #(.LOOP_CYCLES(16)) dnm_engine_end_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .trac_off(eng_trac),
        .link(link));
    dnm_body_end dnm_body_end_inst (
        .pclk(pclk), .presetn(presetn), .run(run), .trac_switch(trac_sw),
        .sso_req(sso_req), .sso_lamp(lamp), .trac_off(body_trac),
        .link(link));
    // second body end faces the bench, which sends headers it must filter
    dnm_body_end dnm_body_end_inst2 (
        .pclk(pclk), .presetn(presetn), .run(run2), .trac_switch(1'b0),
        .sso_req(1'b0), .sso_lamp(lamp2), .trac_off(), .link(link2));
    dnm_link_checker dnm_link_checker_inst (
        .pclk(pclk), .presetn(presetn), .e2b_valid(link.e2b_valid),
        .e2b_hdr(link.e2b_hdr), .e2b_pkt(link.e2b_pkt),
        .b2e_valid(link.b2e_valid), .b2e_hdr(link.b2e_hdr),
        .b2e_pkt(link.b2e_pkt));

    initial pclk = 1'b0;
    always #2 pclk = ~pclk;

    task finish_test;
        $display("tests=%0d errors=%0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : finish_test

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // only the watchdog ends a wait for pready
        do
        begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
        `CHK(e, 1'b0)
    endtask : wr

    task rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        `CHK(r, x)
        `CHK(e, xe)
    endtask : rd

    function logic [40:0] mon(input int s);
        if (s == 0)
            return {link.e2b_valid, link.e2b_hdr};
        if (s == 1)
            return {link.b2e_valid, link.b2e_hdr};
        return {link2.b2e_valid, link2.b2e_hdr};
    endfunction : mon

    task msg(input int s, input logic [39:0] h, input int mx);
        int          k;
        logic [40:0] m;
        k = 0;
        do
        begin
            @(posedge pclk);
            #1;
            m = mon(s);
            k++;
        end while (m[40] !== 1'b1 && k < mx);
        `CHK(m, {1'b1, h})
    endtask : msg

    task quiet(input int s, input int n);
        logic [40:0] m;
        repeat (n)
        begin
            @(posedge pclk);
            #1;
            m = mon(s);
            `CHK(m[40], 1'b0)
        end
    endtask : quiet

    task pulse_req;
        @(posedge pclk);
        sso_req <= 1'b1;
        @(posedge pclk);
        sso_req <= 1'b0;
    endtask : pulse_req

    task send2(input logic [39:0] h);
        @(posedge pclk);
        link2.e2b_valid <= 1'b1;
        link2.e2b_hdr   <= h;
        @(posedge pclk);
        link2.e2b_valid <= 1'b0;
    endtask : send2

    initial
    begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {presetn, run, trac_sw, sso_req, run2} = '0;
        {link2.e2b_valid, link2.e2b_hdr, link2.e2b_pkt} = '0;
        err_count = 0;
        n_tests   = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        `CHK(eng_trac, 1'b0)
        rd(DNM_REG_CTRL, 32'h0, 1'b0);
        rd(DNM_REG_CNT, 32'h0, 1'b0);
        rd(8'h0c, 32'h0, 1'b1);
        @(posedge pclk);
        run <= 1'b1;
        msg(1, 40'h8aea40209b, 8);
        wr(DNM_REG_CTRL, 32'h1);
        msg(0, 40'h8aea10208f, 4);
        msg(0, 40'hcbeb10209b, 2);
        msg(1, 40'haaeb40208f, 3);
        msg(1, 40'h8aea40209b, 3);
        wr(DNM_REG_CTRL, 32'h3);
        msg(0, 40'h8aea10a08f, 20);
        msg(1, 40'haaeb40a08f, 3);
        `CHK(lamp, 1'b1)
        rd(DNM_REG_STAT, 32'h0000000e, 1'b0);
        rd(DNM_REG_CNT, 32'h00020003, 1'b0);
        quiet(0, 40);
        @(posedge pclk);
        trac_sw <= 1'b1;
        msg(1, 40'h8aea40a09b, 10);
        quiet(0, 10);
        `CHK(eng_trac, 1'b1)
        `CHK(body_trac, 1'b1)
        pulse_req();
        msg(1, 40'hcbeb40208f, 3);
        msg(0, 40'h8aea10a08f, 4);
        wr(DNM_REG_CTRL, 32'h7);
        repeat (3) @(posedge pclk);
        `CHK(eng_trac, 1'b0)
        wr(DNM_REG_CTRL, 32'h0);
        pulse_req();
        msg(1, 40'hcbeb40208f, 3);
        quiet(0, 10);
        send2(40'h8aea10a08f);
        quiet(2, 4);
        `CHK(lamp2, 1'b0)
        @(posedge pclk);
        run2 <= 1'b1;
        msg(2, 40'h8aea40209b, 4);
        send2(40'h9aea10a08f);
        quiet(2, 4);
        `CHK(lamp2, 1'b0)
        send2(40'h8aea10a08f);
        msg(2, 40'haaeb40a08f, 3);
        `CHK(lamp2, 1'b1)
        finish_test();
    end

    // the sequence needs under 200 cycles; a hang is cut well past that
    initial
    begin
        #40000;
        err_count++;
        finish_test();
    end
endmodule : driver_notice_msg_handler_tb
